// >>> timer_compare_core.sv
// Eight-bit timer/counter with two compare channels behind an Avalon-MM slave
`timescale 1ns/1ps
module timer_compare_core
	import timer_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [DATA_W-1:0] writedata,
	output logic [DATA_W-1:0] readdata,
	output logic waitrequest,
	input wire logic externalCountPin,
	input wire logic [2:0] intAck,
	output logic [2:0] irqReq,
	output logic compareOutputA,
	output logic compareOutputB,
	output logic topHit,
	output logic bottomHit
);
	timer_ctrl_type ctrl_r, ctrl_nxt;
	logic [CNT_W-1:0] count_r, count_nxt;
	logic [CNT_W-1:0] cmpAWork_r, cmpAWork_nxt, cmpBWork_r, cmpBWork_nxt;
	logic [CNT_W-1:0] cmpABuf_r, cmpABuf_nxt, cmpBBuf_r, cmpBBuf_nxt;
	logic [2:0] mask_r, mask_nxt, flags_r, flags_nxt;
	logic powerOff_r, powerOff_nxt;
	logic countDown_r, countDown_nxt;
	logic block_r, block_nxt;
	logic outA_r, outA_nxt, outB_r, outB_nxt;
	logic [PRE_W-1:0] pre_r, pre_nxt;
	logic extSync1_r, extSync2_r, extPrev_r;
	logic ack_r, ack_nxt;
	logic [DATA_W-1:0] readdata_r, readdata_nxt;
	logic tick, pwm, atTop, atBottom, matchA, matchB, loadPoint;
	logic wrEn, wrCtrlA, wrCtrlB, wrCount, wrCmpA, wrCmpB, forceA, forceB;
	logic [CNT_W-1:0] topVal;
	logic [CNT_W-1:0] wByte;

	function automatic logic isPwm(input waveform_mode_type m);
		return m[0];
	endfunction

	function automatic logic applyAct(input logic cur, input compare_mode_type act);
		unique case (act)
			COM_NONE: return cur;
			COM_TOGGLE: return ~cur;
			COM_CLEAR: return 1'b0;
			COM_SET: return 1'b1;
		endcase
	endfunction

	// Action on a compare match for the current mode
	function automatic compare_mode_type matchAct(input compare_mode_type com, input waveform_mode_type m,
		input logic down, input logic chanA);
		if (!isPwm(m))
			return com;
		if (com == COM_TOGGLE)
			return (chanA && m[2]) ? COM_TOGGLE : COM_NONE;
		if (com == COM_NONE)
			return COM_NONE;
		// Phase correct inverts the action on the way down
		if (!m[1] && down)
			return (com == COM_CLEAR) ? COM_SET : COM_CLEAR;
		return com;
	endfunction

	// Fast PWM restores the output when the count wraps to bottom
	function automatic compare_mode_type wrapAct(input compare_mode_type com, input waveform_mode_type m);
		if (!(isPwm(m) && m[1]))
			return COM_NONE;
		unique case (com)
			COM_CLEAR: return COM_SET;
			COM_SET: return COM_CLEAR;
			default: return COM_NONE;
		endcase
	endfunction

	assign wrEn = write && ack_r;
	assign wByte = writedata[CNT_W-1:0];
	assign wrCtrlA = wrEn && (address == OFF_CTRL_A);
	assign wrCtrlB = wrEn && (address == OFF_CTRL_B);
	assign wrCount = wrEn && (address == OFF_COUNT);
	assign wrCmpA = wrEn && (address == OFF_CMP_A);
	assign wrCmpB = wrEn && (address == OFF_CMP_B);

	// One wait state: read data is prepared while waitrequest is high
	assign waitrequest = (read || write) && !ack_r;
	assign readdata = readdata_r;

	assign pwm = isPwm(ctrl_r.waveMode);
	assign topVal = (ctrl_r.waveMode == WGM_CTC || ctrl_r.waveMode[2]) ? cmpAWork_r : MAX_VAL;
	assign atTop = (count_r == topVal);
	assign atBottom = (count_r == BOTTOM_VAL);
	assign matchA = (count_r == cmpAWork_r);
	assign matchB = (count_r == cmpBWork_r);
	assign loadPoint = tick && atTop;
	assign forceA = wrCtrlB && wByte[CB_FOCA] && !pwm;
	assign forceB = wrCtrlB && wByte[CB_FOCB] && !pwm;

	assign topHit = (count_r == MAX_VAL) || atTop;
	assign bottomHit = atBottom;
	assign compareOutputA = outA_r;
	assign compareOutputB = outB_r;
	assign irqReq = flags_r & mask_r;

	always_comb
	begin
		unique case (ctrl_r.clockSel)
			CS_STOP: tick = 1'b0;
			CS_DIV1: tick = 1'b1;
			CS_DIV8: tick = (pre_r & PRE_MASK_8) == PRE_MASK_8;
			CS_DIV64: tick = (pre_r & PRE_MASK_64) == PRE_MASK_64;
			CS_DIV256: tick = (pre_r & PRE_MASK_256) == PRE_MASK_256;
			CS_DIV1024: tick = (pre_r & PRE_MASK_1024) == PRE_MASK_1024;
			CS_EXT_FALL: tick = extPrev_r && !extSync2_r;
			CS_EXT_RISE: tick = !extPrev_r && extSync2_r;
		endcase
		if (powerOff_r)
			tick = 1'b0;
	end

	// Prescaler stays frozen while powered off
	always_comb
	begin
		pre_nxt = powerOff_r ? pre_r : pre_r + 1'b1;
	end

	// Counter, direction and match blocking
	always_comb
	begin
		count_nxt = count_r;
		countDown_nxt = countDown_r;
		block_nxt = block_r;
		if (tick)
		begin
			block_nxt = 1'b0;
			unique case (ctrl_r.waveMode)
				WGM_CTC, WGM_FAST_MAX, WGM_FAST_CMPA:
					count_nxt = atTop ? BOTTOM_VAL : count_r + 1'b1;
				WGM_PC_MAX, WGM_PC_CMPA:
				begin
					if (!countDown_r && atTop)
					begin
						countDown_nxt = 1'b1;
						count_nxt = count_r - 1'b1;
					end
					else if (countDown_r && atBottom)
					begin
						countDown_nxt = 1'b0;
						count_nxt = count_r + 1'b1;
					end
					else
						count_nxt = countDown_r ? count_r - 1'b1 : count_r + 1'b1;
				end
				default: count_nxt = count_r + 1'b1;
			endcase
		end
		if (wrCount)
		begin
			count_nxt = wByte;
			block_nxt = 1'b1;
		end
	end

	// Compare registers and their buffers
	always_comb
	begin
		cmpAWork_nxt = cmpAWork_r;
		cmpBWork_nxt = cmpBWork_r;
		cmpABuf_nxt = cmpABuf_r;
		cmpBBuf_nxt = cmpBBuf_r;
		if (pwm && loadPoint)
		begin
			cmpAWork_nxt = cmpABuf_r;
			cmpBWork_nxt = cmpBBuf_r;
		end
		if (wrCmpA)
		begin
			cmpABuf_nxt = wByte;
			if (!pwm)
				cmpAWork_nxt = wByte;
		end
		if (wrCmpB)
		begin
			cmpBBuf_nxt = wByte;
			if (!pwm)
				cmpBWork_nxt = wByte;
		end
	end

	// Flags: hardware set wins over any clear
	always_comb
	begin
		logic [2:0] setEv;
		logic [2:0] clrEv;
		setEv = '0;
		clrEv = intAck;
		if (tick)
		begin
			if (pwm && !ctrl_r.waveMode[1])
				setEv[IRQ_OVF] = atBottom;
			else if (pwm)
				setEv[IRQ_OVF] = atTop;
			else
				setEv[IRQ_OVF] = (count_r == MAX_VAL);
		end
		setEv[IRQ_CMPA] = tick && matchA && !block_r;
		setEv[IRQ_CMPB] = tick && matchB && !block_r;
		if (wrEn && address == OFF_FLAGS)
			clrEv = clrEv | writedata[2:0];
		flags_nxt = (flags_r & ~clrEv) | setEv;
	end

	always_comb
	begin
		outA_nxt = outA_r;
		outB_nxt = outB_r;
		if (tick && !block_r)
		begin
			if (matchA)
				outA_nxt = applyAct(outA_nxt, matchAct(ctrl_r.compModeA, ctrl_r.waveMode, countDown_r, 1'b1));
			if (matchB)
				outB_nxt = applyAct(outB_nxt, matchAct(ctrl_r.compModeB, ctrl_r.waveMode, countDown_r, 1'b0));
		end
		if (tick && atTop)
		begin
			outA_nxt = applyAct(outA_nxt, wrapAct(ctrl_r.compModeA, ctrl_r.waveMode));
			outB_nxt = applyAct(outB_nxt, wrapAct(ctrl_r.compModeB, ctrl_r.waveMode));
		end
		// forced match acts only on output
		if (forceA)
			outA_nxt = applyAct(outA_r, ctrl_r.compModeA);
		if (forceB)
			outB_nxt = applyAct(outB_r, ctrl_r.compModeB);
	end

	// Control, mask, power and bus answer
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		mask_nxt = mask_r;
		powerOff_nxt = powerOff_r;
		ack_nxt = (read || write) && !ack_r;
		readdata_nxt = readdata_r;
		if (wrCtrlA)
		begin
			ctrl_nxt.compModeA = compare_mode_type'(wByte[CA_COMA_LSB +: 2]);
			ctrl_nxt.compModeB = compare_mode_type'(wByte[CA_COMB_LSB +: 2]);
			ctrl_nxt.waveMode = waveform_mode_type'({ctrl_r.waveMode[2], wByte[CA_WGM_LSB +: 2]});
		end
		if (wrCtrlB)
		begin
			ctrl_nxt.waveMode = waveform_mode_type'({wByte[CB_WGM2], ctrl_r.waveMode[1:0]});
			ctrl_nxt.clockSel = clock_select_type'(wByte[CB_CS_LSB +: 3]);
		end
		if (wrEn && address == OFF_MASK)
			mask_nxt = writedata[2:0];
		if (wrEn && address == OFF_POWER)
			powerOff_nxt = writedata[POWER_OFF_BIT];
		if (read && !ack_r)
		begin
			readdata_nxt = '0;
			unique case (address)
				OFF_CTRL_A: readdata_nxt[CNT_W-1:0] = {ctrl_r.compModeA, ctrl_r.compModeB, 2'h0,
					ctrl_r.waveMode[1:0]};
				// Force strobes always read as zero
				OFF_CTRL_B: readdata_nxt[CNT_W-1:0] = {4'h0, ctrl_r.waveMode[2], ctrl_r.clockSel};
				OFF_COUNT: readdata_nxt[CNT_W-1:0] = count_r;
				OFF_CMP_A: readdata_nxt[CNT_W-1:0] = pwm ? cmpABuf_r : cmpAWork_r;
				OFF_CMP_B: readdata_nxt[CNT_W-1:0] = pwm ? cmpBBuf_r : cmpBWork_r;
				OFF_MASK: readdata_nxt[2:0] = mask_r;
				OFF_FLAGS: readdata_nxt[2:0] = flags_r;
				OFF_POWER: readdata_nxt[POWER_OFF_BIT] = powerOff_r;
				default: readdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		extSync1_r <= externalCountPin;
		extSync2_r <= extSync1_r;
		extPrev_r <= extSync2_r;
		if (!rst_n)
		begin
			ctrl_r <= CTRL_RESET;
			count_r <= BOTTOM_VAL;
			cmpAWork_r <= BOTTOM_VAL;
			cmpBWork_r <= BOTTOM_VAL;
			cmpABuf_r <= BOTTOM_VAL;
			cmpBBuf_r <= BOTTOM_VAL;
			mask_r <= IRQ_RESET;
			flags_r <= IRQ_RESET;
			powerOff_r <= POWER_RESET;
			countDown_r <= 1'b0;
			block_r <= 1'b0;
			outA_r <= 1'b0;
			outB_r <= 1'b0;
			pre_r <= '0;
			ack_r <= 1'b0;
			readdata_r <= '0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			count_r <= count_nxt;
			cmpAWork_r <= cmpAWork_nxt;
			cmpBWork_r <= cmpBWork_nxt;
			cmpABuf_r <= cmpABuf_nxt;
			cmpBBuf_r <= cmpBBuf_nxt;
			mask_r <= mask_nxt;
			flags_r <= flags_nxt;
			powerOff_r <= powerOff_nxt;
			countDown_r <= countDown_nxt;
			block_r <= block_nxt;
			outA_r <= outA_nxt;
			outB_r <= outB_nxt;
			pre_r <= pre_nxt;
			ack_r <= ack_nxt;
			readdata_r <= readdata_nxt;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	chk_bottom_indication: assert property (count_r == BOTTOM_VAL |-> bottomHit)
		else $error("bottom not indicated at zero");
	chk_max_indication: assert property (count_r == MAX_VAL |-> topHit)
		else $error("max not indicated at 0xFF");
	chk_stopped_holds: assert property (ctrl_r.clockSel == CS_STOP && !wrCount |=> $stable(count_r))
		else $error("counter moved with no clock source");
	chk_write_priority: assert property (wrCount |=> count_r == $past(wByte))
		else $error("counter write lost to count");
	chk_flag_on_tick: assert property (tick && matchA && !block_r |=> flags_r[IRQ_CMPA])
		else $error("compare A flag not set on tick");
	chk_block_after_write: assert property (wrCount ##1 (tick && !flags_r[IRQ_CMPB]) |=> !flags_r[IRQ_CMPB])
		else $error("match not blocked after counter write");
	chk_force_no_flag: assert property (forceA && !tick && !flags_r[IRQ_CMPA] |=> !flags_r[IRQ_CMPA])
		else $error("forced match set the flag");
	chk_mask_gate: assert property (!mask_r[IRQ_OVF] |-> !irqReq[IRQ_OVF])
		else $error("masked overflow request raised");
	chk_power_stall: assert property (powerOff_r && !wrCount |=> $stable(count_r))
		else $error("counter ran while powered off");
	chk_none_no_action: assert property (ctrl_r.compModeB == COM_NONE && !wrCtrlA |=> $stable(outB_r))
		else $error("output B changed with mode none");
	chk_buffer_hold: assert property (pwm && !loadPoint |=> $stable(cmpAWork_r))
		else $error("working compare A changed outside top");
	chk_bus_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("bus answer later than one wait state");

	cov_overflow: cover property (tick && !flags_r[IRQ_OVF] ##1 flags_r[IRQ_OVF]);
	cov_force_ctc: cover property (forceA && ctrl_r.waveMode == WGM_CTC);
	cov_phase_turn: cover property (!countDown_r ##1 countDown_r);
	cov_buffer_load: cover property (pwm && loadPoint && cmpABuf_r != cmpAWork_r);
endmodule

// >>> timer_pkg.sv
// Constants, types and field layout for the 8-bit timer with two compare channels
// Functional notes
// - Counter at 0x00 means bottom
// - Counter at 0xFF means max
// - Top is 0xFF or compare A per mode
// - Counter and compare registers are 8 bits
// - Each request flagged and individually masked
// - Tick from prescaler or external pin edge
// - Clock select zero stops the counter
// - Tick clears, increments or decrements per mode
// - CPU reads and writes counter anytime
// - CPU counter write beats clear or count
// - Mode field split across control A and B
// - Overflow flag set per mode, raises request
// - Two comparators check counter continuously
// - Match sets compare flag on next tick
// - Flag clears on service or write one
// - Outputs from match, mode and output mode
// - Compare buffering only in PWM modes
// - Buffer loads working compare at top only
// - CPU reaches buffer or working register
// - Force strobe forces match in non-PWM modes
// - Forced match: no flag, no counter change
// - Counter write blocks matches next tick
// - Output mode zero takes no action
package timer_pkg;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int CNT_W = 8;
	localparam int PRE_W = 10;
	localparam logic [ADDR_W-1:0] OFF_CTRL_A = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_CTRL_B = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_COUNT = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_CMP_A = 5'h0C;
	localparam logic [ADDR_W-1:0] OFF_CMP_B = 5'h10;
	localparam logic [ADDR_W-1:0] OFF_MASK = 5'h14;
	localparam logic [ADDR_W-1:0] OFF_FLAGS = 5'h18;
	localparam logic [ADDR_W-1:0] OFF_POWER = 5'h1C;
	// Control A: [7:6] mode A, [5:4] mode B, [1:0] low mode bits
	localparam int CA_COMA_LSB = 6;
	localparam int CA_COMB_LSB = 4;
	localparam int CA_WGM_LSB = 0;
	// Control B: [7] force A, [6] force B, [3] high mode bit, [2:0] clock select
	localparam int CB_FOCA = 7;
	localparam int CB_FOCB = 6;
	localparam int CB_WGM2 = 3;
	localparam int CB_CS_LSB = 0;
	localparam int IRQ_OVF = 0;
	localparam int IRQ_CMPA = 1;
	localparam int IRQ_CMPB = 2;
	localparam int POWER_OFF_BIT = 0;
	localparam logic [CNT_W-1:0] BOTTOM_VAL = 8'h00;
	localparam logic [CNT_W-1:0] MAX_VAL = 8'hFF;
	localparam logic [PRE_W-1:0] PRE_MASK_8 = 10'h007;
	localparam logic [PRE_W-1:0] PRE_MASK_64 = 10'h03F;
	localparam logic [PRE_W-1:0] PRE_MASK_256 = 10'h0FF;
	localparam logic [PRE_W-1:0] PRE_MASK_1024 = 10'h3FF;
	localparam logic [2:0] IRQ_RESET = 3'h0;
	localparam logic POWER_RESET = 1'b0;
	typedef enum logic [2:0] {
		CS_STOP = 3'b000, CS_DIV1 = 3'b001, CS_DIV8 = 3'b010, CS_DIV64 = 3'b011,
		CS_DIV256 = 3'b100, CS_DIV1024 = 3'b101, CS_EXT_FALL = 3'b110, CS_EXT_RISE = 3'b111
	} clock_select_type;
	typedef enum logic [2:0] {
		WGM_NORMAL = 3'b000, WGM_PC_MAX = 3'b001, WGM_CTC = 3'b010, WGM_FAST_MAX = 3'b011,
		WGM_RSV4 = 3'b100, WGM_PC_CMPA = 3'b101, WGM_RSV6 = 3'b110, WGM_FAST_CMPA = 3'b111
	} waveform_mode_type;
	typedef enum logic [1:0] {
		COM_NONE = 2'b00, COM_TOGGLE = 2'b01, COM_CLEAR = 2'b10, COM_SET = 2'b11
	} compare_mode_type;
	typedef struct packed {
		compare_mode_type compModeA;
		compare_mode_type compModeB;
		waveform_mode_type waveMode;
		clock_select_type clockSel;
	} timer_ctrl_type;
	localparam timer_ctrl_type CTRL_RESET = '{COM_NONE, COM_NONE, WGM_NORMAL, CS_STOP};
endpackage

// >>> cpu_bus_model.sv
// CPU-side register bus master driving the timer core
`timescale 1ns/1ps
module cpu_bus_model
	import timer_pkg::*;
(
	input wire logic core_clk,
	output logic [ADDR_W-1:0] address,
	output logic read,
	output logic write,
	output logic [DATA_W-1:0] writedata,
	input wire logic [DATA_W-1:0] readdata,
	input wire logic waitrequest,
	output logic hung
);
	initial
	begin
		address = '0;
		read = 1'b0;
		write = 1'b0;
		writedata = '0;
		hung = 1'b0;
	end
	// Samples at the rising edge see pre-edge values, so the answer is taken where waitrequest is low
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] q);
		int n;
		logic w;
		n = 0;
		w = 1'b1;
		q = '0;
		@(posedge core_clk);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= d;
		while (w && n < 50)
		begin
			@(posedge core_clk);
			w = waitrequest;
			q = readdata;
			n++;
		end
		read <= 1'b0;
		write <= 1'b0;
		if (w)
			hung <= 1'b1;
	endtask
endmodule

// >>> eight_bit_timer_compare_core_test.sv
// Self-checking bench for the eight-bit timer compare core
`timescale 1ns/1ps
module eight_bit_timer_compare_core_test
	import timer_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] address;
	logic read;
	logic write;
	logic [DATA_W-1:0] writedata;
	logic [DATA_W-1:0] readdata;
	logic waitrequest;
	logic extPin = 1'b0;
	logic [2:0] intAck = 3'h0;
	logic [2:0] irqReq;
	logic outA;
	logic outB;
	logic topHit;
	logic bottomHit;
	logic hung;
	int err_total = 0;
	int cmp_count = 0;
	logic [15:0] lfsrState = 16'h9605;

	always #2 core_clk = ~core_clk;

	timer_compare_core i_dut (.core_clk(core_clk), .rst_n(rst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.externalCountPin(extPin), .intAck(intAck), .irqReq(irqReq), .compareOutputA(outA),
		.compareOutputB(outB), .topHit(topHit), .bottomHit(bottomHit));
	cpu_bus_model i_cpu (.core_clk(core_clk), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .hung(hung));

	function automatic logic [15:0] lfsrNext(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic forceOut(input compare_mode_type m, input logic old);
		case (m)
			COM_TOGGLE: return ~old;
			COM_CLEAR: return 1'b0;
			COM_SET: return 1'b1;
			default: return old;
		endcase
	endfunction

	task automatic cmpWord(input string name, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
		cmp_count++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic cmpBit(input string name, input logic e, input logic g);
		cmp_count++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch %s expected %b seen %b", name, e, g);
		end
	endtask
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic [DATA_W-1:0] q;
		i_cpu.xfer(1'b1, a, {24'h000000, d}, q);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
		i_cpu.xfer(1'b0, a, 32'h00000000, q);
	endtask
	task automatic rdChk(input string name, input logic [ADDR_W-1:0] a, input logic [7:0] e);
		logic [DATA_W-1:0] q;
		rd(a, q);
		cmpWord(name, {24'h000000, e}, q);
	endtask
	// Pin held long enough for the two-stage sync and edge detect
	task automatic pulses(input int n);
		repeat (n)
		begin
			@(posedge core_clk);
			extPin <= 1'b1;
			repeat (6) @(posedge core_clk);
			extPin <= 1'b0;
			repeat (6) @(posedge core_clk);
		end
	endtask

	always @(posedge hung)
	begin
		err_total++;
		results();
	end
	initial
	begin
		#400000;
		err_total++;
		results();
	end

	initial
	begin
		logic [DATA_W-1:0] q;
		logic [7:0] v;
		logic e;
		compare_mode_type m;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++)
			rdChk("reset value", ADDR_W'(i * 4), 8'h00);
		// Corner counts first, then random ones, timer stopped
		for (int i = 0; i < 12; i++)
		begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : lfsrState[7:0];
			lfsrState = lfsrNext(lfsrState);
			wr(OFF_COUNT, v);
			repeat (3) @(posedge core_clk);
			rdChk("count", OFF_COUNT, v);
			@(negedge core_clk);
			cmpBit("bottom", v == 8'h00, bottomHit);
			cmpBit("top", v == 8'hFF, topHit);
		end
		wr(OFF_POWER, 8'h01);
		wr(OFF_COUNT, 8'h10);
		wr(OFF_CTRL_B, 8'h01);
		repeat (20) @(posedge core_clk);
		rdChk("frozen count", OFF_COUNT, 8'h10);
		wr(OFF_POWER, 8'h00);
		rd(OFF_COUNT, q);
		cmpBit("running", 1'b1, q[7:0] !== 8'h10);
		wr(OFF_CTRL_B, 8'h00);
		wr(OFF_COUNT, 8'hFE);
		wr(OFF_FLAGS, 8'h07);
		wr(OFF_CTRL_B, 8'h07);
		pulses(1);
		rdChk("flags before wrap", OFF_FLAGS, 8'h00);
		pulses(1);
		rdChk("overflow flag", OFF_FLAGS, 8'h01);
		pulses(1);
		rdChk("all flags", OFF_FLAGS, 8'h07);
		rdChk("count after wrap", OFF_COUNT, 8'h01);
		wr(OFF_MASK, 8'h02);
		@(negedge core_clk);
		cmpWord("irq masked", 32'h00000002, {29'h0, irqReq});
		@(posedge core_clk);
		intAck <= 3'b010;
		@(posedge core_clk);
		intAck <= 3'b000;
		rdChk("serviced flag", OFF_FLAGS, 8'h05);
		wr(OFF_FLAGS, 8'h01);
		rdChk("written flag", OFF_FLAGS, 8'h04);
		@(negedge core_clk);
		cmpWord("irq gated", 32'h00000000, {29'h0, irqReq});
		wr(OFF_CTRL_B, 8'h00);
		wr(OFF_FLAGS, 8'h07);
		wr(OFF_CMP_A, 8'h05);
		wr(OFF_COUNT, 8'h03);
		wr(OFF_CTRL_B, 8'h07);
		pulses(2);
		rdChk("match not yet flagged", OFF_FLAGS, 8'h00);
		pulses(1);
		rdChk("match flagged", OFF_FLAGS, 8'h02);
		wr(OFF_CTRL_B, 8'h00);
		wr(OFF_FLAGS, 8'h07);
		wr(OFF_COUNT, 8'h05);
		wr(OFF_CTRL_B, 8'h07);
		pulses(1);
		rdChk("blocked match", OFF_FLAGS, 8'h00);
		wr(OFF_CTRL_B, 8'h00);
		e = 1'b0;
		for (int i = 0; i < 7; i++)
		begin
			m = compare_mode_type'(i < 4 ? 2'(3 - i) : lfsrState[1:0]);
			lfsrState = lfsrNext(lfsrState);
			wr(OFF_CTRL_A, {m, m, 4'h0});
			wr(OFF_CTRL_B, 8'hC0);
			@(negedge core_clk);
			e = forceOut(m, e);
			cmpBit("forced A", e, outA);
			cmpBit("forced B", e, outB);
		end
		rdChk("no forced flag", OFF_FLAGS, 8'h00);
		rdChk("count kept", OFF_COUNT, 8'h06);
		wr(OFF_CTRL_A, 8'h02);
		wr(OFF_COUNT, 8'h20);
		wr(OFF_CMP_A, 8'h20);
		@(negedge core_clk);
		cmpBit("direct top", 1'b1, topHit);
		wr(OFF_CTRL_A, 8'h03);
		wr(OFF_CTRL_B, 8'h08);
		wr(OFF_CMP_A, 8'h40);
		@(negedge core_clk);
		cmpBit("buffered top", 1'b1, topHit);
		rdChk("buffer read", OFF_CMP_A, 8'h40);
		wr(OFF_CTRL_B, 8'h0F);
		pulses(1);
		wr(OFF_CTRL_B, 8'h08);
		wr(OFF_COUNT, 8'h40);
		@(negedge core_clk);
		cmpBit("loaded top", 1'b1, topHit);
		wr(OFF_COUNT, 8'h20);
		@(negedge core_clk);
		cmpBit("old top gone", 1'b0, topHit);
		// Phase correct turn at top, then falling-edge ticks downward
		wr(OFF_CTRL_A, 8'h01);
		wr(OFF_CTRL_B, 8'h00);
		wr(OFF_COUNT, 8'hFE);
		wr(OFF_CTRL_B, 8'h07);
		pulses(2);
		rdChk("down count", OFF_COUNT, 8'hFE);
		wr(OFF_CTRL_B, 8'h06);
		pulses(1);
		rdChk("falling tick", OFF_COUNT, 8'hFD);
		wr(OFF_FLAGS, 8'h07);
		wr(OFF_COUNT, 8'h01);
		pulses(2);
		rdChk("bottom turn flags", OFF_FLAGS, 8'h05);
		rdChk("up after bottom", OFF_COUNT, 8'h01);
		// Divide by eight over 83 selected cycles gives 10 or 11 ticks
		wr(OFF_CTRL_A, 8'h00);
		wr(OFF_COUNT, 8'h00);
		wr(OFF_CTRL_B, 8'h02);
		repeat (80) @(posedge core_clk);
		wr(OFF_CTRL_B, 8'h00);
		rd(OFF_COUNT, q);
		cmpBit("prescaled rate", 1'b1, q[7:0] >= 8'h0A && q[7:0] <= 8'h0B);
		results();
	end
endmodule
